/* hdl/tccu_capture_compare.sv */
// Purpose: Capture/compare logic around the 16-bit timer up-counter
// Assumes: countTick is a one-cycle enable from the prescaler
// Notes:   Triggers are pins, filtered through three flip-flops

`timescale 1ns/1ps

// Contract
// - Zero compare: no match at start
// - Zero compare matches on 0 to 1
// - Delayed zero match after every clear
// - Source 1: A captures opposite trigger-A edge
// - Reverse phase: trigger B only interrupts A
// - Source 0: A captures trigger-B edge
// - B captures trigger-A edge, interrupts
// - Compare equality raises match interrupt
// - Counter counts ticks, stop clears
module tccu_capture_compare (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                countTick,
   input  wire tccu_pkg::tccu_ctrl_t ctrl,
   input  wire tccu_pkg::tccu_wr_t   wr,
   input  wire logic                triggerInputA,
   input  wire logic                triggerInputB,
   output logic [15:0]              upCounter,
   output logic [15:0]              compareCaptureA,
   output logic [15:0]              compareCaptureB,
   output logic                     matchIrqA,
   output logic                     matchIrqB,
   output logic                     overflow
);

   tccu_pkg::tccu_state_t state_reg;
   tccu_pkg::tccu_state_t state_next;

   logic running;
   logic riseA;
   logic fallA;
   logic riseB;
   logic fallB;
   logic validA;
   logic reverseA;
   logic validB;
   logic tickRun;
   logic matchA;
   logic matchB;

   // ****************************************
   // Edge qualification
   // ****************************************
   function automatic logic edge_pick(input logic [1:0] sel,
                                      input logic rise,
                                      input logic fall);
      logic hit;
      hit = 1'b0;
      if (sel == tccu_pkg::EDGE_RISING) begin
         hit = rise;
      end else if (sel == tccu_pkg::EDGE_FALLING) begin
         hit = fall;
      end else if (sel == tccu_pkg::EDGE_BOTH) begin
         hit = rise | fall;
      end
      return hit;
   endfunction

   // Filtered level changes only when the two later stages agree
   always_comb begin
      riseA = 1'b0;
      fallA = 1'b0;
      riseB = 1'b0;
      fallB = 1'b0;
      if (state_reg.syncA[tccu_pkg::SYNC_MID]
          == state_reg.syncA[tccu_pkg::SYNC_LAST]) begin
         riseA = state_reg.syncA[tccu_pkg::SYNC_LAST] & ~state_reg.levelA;
         fallA = ~state_reg.syncA[tccu_pkg::SYNC_LAST] & state_reg.levelA;
      end
      if (state_reg.syncB[tccu_pkg::SYNC_MID]
          == state_reg.syncB[tccu_pkg::SYNC_LAST]) begin
         riseB = state_reg.syncB[tccu_pkg::SYNC_LAST] & ~state_reg.levelB;
         fallB = ~state_reg.syncB[tccu_pkg::SYNC_LAST] & state_reg.levelB;
      end
   end

   assign validA = edge_pick(ctrl.edgeSelectA, riseA, fallA);
   assign validB = edge_pick(ctrl.edgeSelectB, riseB, fallB);
   // opposite edge
   // Both-edge setting leaves no opposite edge, so source 1 never captures into compareCaptureA
   assign reverseA = (ctrl.edgeSelectA == tccu_pkg::EDGE_RISING) ? fallA :
                     (ctrl.edgeSelectA == tccu_pkg::EDGE_FALLING) ? riseA :
                     1'b0;

   assign running = (ctrl.runMode != tccu_pkg::RUN_STOP);
   assign tickRun = running & countTick;
   // zero on step
   // Equality is judged on the counting edge, so a zero value fires as
   // the counter steps from zero to one, never at the bare zero count
   assign matchA = tickRun & ~ctrl.captureModeA
                 & (state_reg.upCounter == state_reg.compareCaptureA);
   assign matchB = tickRun & ~ctrl.captureModeB
                 & (state_reg.upCounter == state_reg.compareCaptureB);

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_next = state_reg;
      state_next.syncA = {state_reg.syncA[tccu_pkg::SYNC_MID:0],
                          triggerInputA};
      state_next.syncB = {state_reg.syncB[tccu_pkg::SYNC_MID:0],
                          triggerInputB};
      if (state_reg.syncA[tccu_pkg::SYNC_MID]
          == state_reg.syncA[tccu_pkg::SYNC_LAST]) begin
         state_next.levelA = state_reg.syncA[tccu_pkg::SYNC_LAST];
      end
      if (state_reg.syncB[tccu_pkg::SYNC_MID]
          == state_reg.syncB[tccu_pkg::SYNC_LAST]) begin
         state_next.levelB = state_reg.syncB[tccu_pkg::SYNC_LAST];
      end
      state_next.matchIrqA = 1'b0;
      state_next.matchIrqB = 1'b0;

      if (!running) begin
         state_next.upCounter = tccu_pkg::COUNT_ZERO;
         state_next.overflow  = 1'b0;
      end else if (ctrl.runMode == tccu_pkg::RUN_CLEAR_TRIG && validA) begin
         state_next.upCounter = tccu_pkg::COUNT_ZERO;
      end else if (ctrl.runMode == tccu_pkg::RUN_CLEAR_CMP && matchA) begin
         state_next.upCounter = tccu_pkg::COUNT_ZERO;
      end else if (tickRun) begin
         state_next.upCounter = 16'(state_reg.upCounter
                                    + tccu_pkg::COUNT_ONE);
      end
      // A clear that lands on the wrapping tick still counts as overflow
      if (tickRun && state_reg.upCounter == tccu_pkg::COUNT_MAX) begin
         state_next.overflow = 1'b1;
      end

      // Software loads first; a capture in the same cycle wins
      if (wr.writeA) begin
         state_next.compareCaptureA = wr.data;
      end
      if (wr.writeB) begin
         state_next.compareCaptureB = wr.data;
      end

      if (ctrl.captureModeA) begin
         if (ctrl.captureSourceSelect) begin
            if (reverseA) begin
               state_next.compareCaptureA = state_reg.upCounter;
            end
            state_next.matchIrqA = validB;
         end else begin
            if (validB) begin
               state_next.compareCaptureA = state_reg.upCounter;
               state_next.matchIrqA       = 1'b1;
            end
         end
      end else begin
         state_next.matchIrqA = matchA;
      end

      if (ctrl.captureModeB) begin
         if (validA) begin
            state_next.compareCaptureB = state_reg.upCounter;
            state_next.matchIrqB       = 1'b1;
         end
      end else begin
         state_next.matchIrqB = matchB;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= tccu_pkg::STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign upCounter       = state_reg.upCounter;
   assign compareCaptureA = state_reg.compareCaptureA;
   assign compareCaptureB = state_reg.compareCaptureB;
   assign matchIrqA       = state_reg.matchIrqA;
   assign matchIrqB       = state_reg.matchIrqB;
   assign overflow        = state_reg.overflow;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_stop_clears: assert property (
      !running |=> upCounter == tccu_pkg::COUNT_ZERO)
      else $error("counter not cleared while stopped");

   a_count_step: assert property (
      tickRun && ctrl.runMode == tccu_pkg::RUN_FREE
      ##0 $stable(ctrl.runMode)
      |=> upCounter == 16'($past(upCounter) + tccu_pkg::COUNT_ONE))
      else $error("counter did not step on tick");

   a_zero_start: assert property (
      !ctrl.captureModeA && compareCaptureA == tccu_pkg::COUNT_ZERO
      && !countTick |=> !matchIrqA)
      else $error("zero compare fired without a step");

   a_zero_step: assert property (
      matchIrqA && !$past(ctrl.captureModeA)
      |-> $past(tickRun) && $past(upCounter) == $past(compareCaptureA))
      else $error("match interrupt without equality at step");

   a_wrap_clear: assert property (
      tickRun && upCounter == tccu_pkg::COUNT_MAX
      |=> upCounter == tccu_pkg::COUNT_ZERO && overflow)
      else $error("overflow did not clear counter");

   a_both_none: assert property (
      ctrl.captureModeA && ctrl.captureSourceSelect && !wr.writeA
      && ctrl.edgeSelectA == tccu_pkg::EDGE_BOTH
      |=> compareCaptureA == $past(compareCaptureA))
      else $error("capture on both-edge reverse setting");

   a_reverse_irq: assert property (
      ctrl.captureModeA && ctrl.captureSourceSelect && validB
      && !reverseA && !wr.writeA
      |=> matchIrqA && compareCaptureA == $past(compareCaptureA))
      else $error("trigger B mishandled in reverse phase");

   a_capture_a: assert property (
      ctrl.captureModeA && !ctrl.captureSourceSelect && validB
      |=> matchIrqA && compareCaptureA == $past(upCounter))
      else $error("capture A from trigger B failed");

   a_capture_b: assert property (
      ctrl.captureModeB && validA
      |=> matchIrqB && compareCaptureB == $past(upCounter))
      else $error("capture B from trigger A failed");

   c_zero_match: cover property (
      compareCaptureA == tccu_pkg::COUNT_ZERO ##1 matchIrqA);
   c_reverse_cap: cover property (
      ctrl.captureSourceSelect && ctrl.captureModeA && reverseA);
   c_capture_b: cover property (ctrl.captureModeB ##0 validA ##1 matchIrqB);

endmodule

/* hdl/tccu_pkg.sv */
// Purpose: Shared constants and carrier types of the capture/compare unit
// Assumes: 16-bit up-counter, two capture/compare registers
// Notes:   Edge code 2'b10 has no meaning and selects no edge

package tccu_pkg;

   // ****************************************
   // Counter and register values
   // ****************************************
   localparam int          COUNT_WIDTH = 16;
   localparam logic [15:0] COUNT_ZERO  = 16'h0000;
   localparam logic [15:0] COUNT_ONE   = 16'h0001;
   localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
   localparam logic [15:0] CC_RESET    = 16'h0000;

   // ****************************************
   // Run mode and edge field codes
   // ****************************************
   localparam logic [1:0] RUN_STOP       = 2'h0;
   localparam logic [1:0] RUN_FREE       = 2'h1;
   localparam logic [1:0] RUN_CLEAR_TRIG = 2'h2;
   localparam logic [1:0] RUN_CLEAR_CMP  = 2'h3;
   localparam logic [1:0] EDGE_FALLING   = 2'h0;
   localparam logic [1:0] EDGE_RISING    = 2'h1;
   localparam logic [1:0] EDGE_BOTH      = 2'h3;

   // ****************************************
   // Synchroniser layout
   // ****************************************
   localparam int SYNC_DEPTH = 3;
   localparam int SYNC_FIRST = 0;
   localparam int SYNC_MID   = 1;
   localparam int SYNC_LAST  = 2;

   // Software control bits, kept together
   typedef struct packed {
      logic [1:0] runMode;
      logic       captureModeA;
      logic       captureModeB;
      logic       captureSourceSelect;
      logic [1:0] edgeSelectA;
      logic [1:0] edgeSelectB;
   } tccu_ctrl_t;

   // Software write port of the two compare values
   typedef struct packed {
      logic        writeA;
      logic        writeB;
      logic [15:0] data;
   } tccu_wr_t;

   // Whole state of the unit
   typedef struct packed {
      logic [SYNC_DEPTH-1:0] syncA;
      logic [SYNC_DEPTH-1:0] syncB;
      logic                  levelA;
      logic                  levelB;
      logic [15:0]           upCounter;
      logic [15:0]           compareCaptureA;
      logic [15:0]           compareCaptureB;
      logic                  matchIrqA;
      logic                  matchIrqB;
      logic                  overflow;
   } tccu_state_t;

   localparam tccu_state_t STATE_RESET = '{
      syncA: '0, syncB: '0, levelA: 1'b0, levelB: 1'b0,
      upCounter: COUNT_ZERO, compareCaptureA: CC_RESET,
      compareCaptureB: CC_RESET, matchIrqA: 1'b0, matchIrqB: 1'b0,
      overflow: 1'b0};

endpackage

/* verification/tccu_pin_model.sv */
// Purpose: Model of the two external trigger pins
// Assumes: Levels are requested by the bench sequencer
// Notes:   Pins move only on the falling edge of clk

`timescale 1ns/1ps

module tccu_pin_model (
   input  wire logic clk,
   input  wire logic levelA,
   input  wire logic levelB,
   output logic      triggerInputA,
   output logic      triggerInputB
);
   initial begin
      triggerInputA = 1'b0;
      triggerInputB = 1'b0;
   end
   // Levels held six cycles, past the filter depth
   always @(negedge clk) begin
      triggerInputA <= levelA;
      triggerInputB <= levelB;
   end
endmodule

/* verification/timer_capture_compare_unit_tb_top.sv */
// Purpose: Self-checking bench of the capture/compare unit
// Assumes: Inputs driven at the falling edge of clk
// Notes:   Ticks are stopped before captures so values are known

`timescale 1ns/1ps

`define CHK(n, e, g) begin cmpCount++; if ((e) !== (g)) begin \
   $display("unexpected %s exp %0h got %0h", n, e, g); fails++; end end

module timer_capture_compare_unit_tb_top;
   logic                 clk       = 1'b0;
   logic                 reset     = 1'b1;
   logic                 countTick = 1'b0;
   tccu_pkg::tccu_ctrl_t ctrl      = '0;
   tccu_pkg::tccu_ctrl_t c         = '0;
   tccu_pkg::tccu_wr_t   wr        = '0;
   logic                 pinA      = 1'b0;
   logic                 pinB      = 1'b0;
   logic                 trigA;
   logic                 trigB;
   logic [15:0]          upCounter;
   logic [15:0]          capA;
   logic [15:0]          capB;
   logic [15:0]          atA;
   logic [15:0]          atB;
   logic                 irqA;
   logic                 irqB;
   logic                 ovf;
   logic [1:0]           codes [3];
   int                   expN  [3];
   int                   fails    = 0;
   int                   cmpCount = 0;
   int                   nA       = 0;
   int                   nB       = 0;
   int                   cycles   = 0;

   tccu_pin_model pins (.clk(clk), .levelA(pinA), .levelB(pinB),
      .triggerInputA(trigA), .triggerInputB(trigB));

   tccu_capture_compare uut (.clk(clk), .reset(reset),
      .countTick(countTick), .ctrl(ctrl), .wr(wr),
      .triggerInputA(trigA), .triggerInputB(trigB),
      .upCounter(upCounter), .compareCaptureA(capA),
      .compareCaptureB(capB), .matchIrqA(irqA), .matchIrqB(irqB),
      .overflow(ovf));

   always #20 clk = ~clk;

   // Interrupt pulses counted with the count they came with
   always @(posedge clk) begin
      cycles++;
      if (irqA === 1'b1) begin
         nA++;
         atA = upCounter;
      end
      if (irqB === 1'b1) begin
         nB++;
         atB = upCounter;
      end
      // Ceiling covers the full wrap run plus the short tests
      if (cycles == 70000) begin
         fails++;
         completeRun();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(negedge clk);
         countTick = 1'b1;
      end
      @(negedge clk);
      countTick = 1'b0;
   endtask

   task automatic wrCmp(input logic a, input logic [15:0] d);
      @(negedge clk);
      wr = '{writeA: a, writeB: !a, data: d};
      @(negedge clk);
      wr = '0;
   endtask

   // Control changed only while stopped
   task automatic restart(input logic [1:0] m, input tccu_pkg::tccu_ctrl_t k);
      @(negedge clk);
      ctrl.runMode = tccu_pkg::RUN_STOP;
      k.runMode = m;
      @(negedge clk);
      ctrl = k;
      nA = 0;
      nB = 0;
   endtask

   // Non-blocking so the pin model never races the level change
   task automatic pulse(input logic a);
      pinA <= a;
      pinB <= !a;
      cyc(6);
      pinA <= 1'b0;
      pinB <= 1'b0;
      cyc(6);
   endtask

   task automatic completeRun();
      $display("checks %0d mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      codes = '{tccu_pkg::EDGE_FALLING, tccu_pkg::EDGE_RISING,
                tccu_pkg::EDGE_BOTH};
      expN = '{1, 1, 2};
      cyc(20);
      reset = 1'b0;
      cyc(1);
      `CHK("count", 16'h0000, upCounter)
      tick(3);
      `CHK("stopped", 16'h0000, upCounter)
      restart(tccu_pkg::RUN_FREE, c);
      tick(5);
      `CHK("count", 16'h0005, upCounter)
      `CHK("no wrap yet", 1'b0, ovf)
      tick(65531);
      `CHK("wrapped", 16'h0000, upCounter)
      `CHK("overflow", 1'b1, ovf)
      restart(tccu_pkg::RUN_STOP, c);
      `CHK("cleared", 16'h0000, upCounter)
      `CHK("ovf cleared", 1'b0, ovf)
      $display("test counter done");
      wrCmp(1'b1, 16'h0000);
      wrCmp(1'b0, 16'h0000);
      restart(tccu_pkg::RUN_FREE, c);
      cyc(3);
      `CHK("no start irq", 0, nA)
      tick(3);
      cyc(2);
      `CHK("zero irqA", 1, nA)
      `CHK("zero at", 16'h0001, atA)
      `CHK("zero irqB", 1, nB)
      $display("test zero compare done");
      wrCmp(1'b1, 16'h0004);
      restart(tccu_pkg::RUN_CLEAR_CMP, c);
      tick(7);
      cyc(2);
      `CHK("match irqA", 1, nA)
      `CHK("after clear", 2, nB)
      `CHK("after at", 16'h0001, atB)
      `CHK("cleared count", 16'h0002, upCounter)
      c.edgeSelectA = tccu_pkg::EDGE_RISING;
      restart(tccu_pkg::RUN_CLEAR_TRIG, c);
      tick(5);
      pulse(1'b1);
      `CHK("trig clear", 16'h0000, upCounter)
      tick(1);
      cyc(2);
      `CHK("trig irqB", 2, nB)
      $display("test clear modes done");
      c.captureModeA = 1'b1;
      c.captureModeB = 1'b1;
      for (int i = 0; i < 3; i++) begin
         c.edgeSelectA = codes[i];
         c.edgeSelectB = codes[i];
         restart(tccu_pkg::RUN_FREE, c);
         tick(i + 1);
         pulse(1'b0);
         `CHK("capA", 16'(i + 1), capA)
         `CHK("capA irq", expN[i], nA)
         pulse(1'b1);
         `CHK("capB", 16'(i + 1), capB)
         `CHK("capB irq", expN[i], nB)
      end
      $display("test edge codes done");
      c.captureSourceSelect = 1'b1;
      c.edgeSelectA = tccu_pkg::EDGE_RISING;
      c.edgeSelectB = tccu_pkg::EDGE_RISING;
      restart(tccu_pkg::RUN_FREE, c);
      tick(7);
      pulse(1'b1);
      `CHK("rev capA", 16'h0007, capA)
      `CHK("rev irqA", 0, nA)
      `CHK("rev capB", 16'h0007, capB)
      c.edgeSelectA = tccu_pkg::EDGE_BOTH;
      restart(tccu_pkg::RUN_FREE, c);
      tick(2);
      pulse(1'b1);
      `CHK("both capA", 16'h0007, capA)
      `CHK("both capB", 16'h0002, capB)
      pulse(1'b0);
      `CHK("ext irqA", 1, nA)
      `CHK("ext capA", 16'h0007, capA)
      $display("test reverse phase done");
      completeRun();
   end
endmodule
